/* File: dbeh_top.sv */
// downstream error handler: forwarding, status, header log, messages, completions
//
// Contract
// - poisoned payload forwarded with inverted parity
// - ECRC-errored request dropped, never forwarded
// - read data error gives successful poisoned completion
// - write error/master-abort UR, target-abort CA
// - advisory non-fatal sets correctable and advisory bits
// - unmasked advisory sets status, logs, correctable message
// - advisory poisoned unmasked: message, bits, log
// - advisory poisoned masked: no message, bits set
// - fatal poisoned: fatal message, bits, log, SSE
// - poison sets parity error, read master parity
// - parity pin on poisoned write: status, log
// - ECRC drop sets parity, ECRC status, log
// - ECRC message per severity, SSE, detected bit
// - read data error: status bits, drive parity pin
// - read data error: log and severity message
// - keep fetching, then poisoned successful completion
// - detected bits set regardless of report enables
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "dbeh_map.svh"
module dbeh_top
(
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // apb slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  // downstream events from the datapath
  input  wire logic         ev_poison,
  input  wire logic         ev_poison_cpl,
  input  wire logic         ev_ecrc,
  input  wire logic [127:0] ev_hdr,
  // pci data phase
  input  wire logic         dp_par,
  input  wire logic         dp_poison,
  input  wire logic         fwd_poison_wr,
  output logic              pci_par_out,
  output logic              fwd_drop,
  // immediate read
  input  wire logic         rd_start,
  input  wire logic         rd_err,
  input  wire logic         rd_end,
  // immediate non-posted termination
  input  wire logic         term_valid,
  input  wire logic [1:0]   term_kind,
  // completion to pcie
  output logic              cpl_valid,
  output logic [2:0]        cpl_status,
  output logic              cpl_poison,
  // error message to pcie
  output logic              msg_valid,
  output logic [1:0]        msg_code,
  // pci parity error pin
  input  wire logic         pci_parity_error_pin_in_n,
  output logic              pci_parity_error_pin_out_n,
  output logic              pci_parity_error_pin_oe_n,
  // interrupt
  output logic              irq
);
  // ****************************************************************
  // registers
  // ****************************************************************
  logic [5:0]   ctrl_r;
  logic [6:0]   devstat_r;
  logic [6:0]   imask_r;
  logic [1:0]   uncstat_r;
  logic [1:0]   uncmask_r;
  logic [1:0]   uncsev_r;
  logic         corstat_r;
  logic         cormask_r;
  logic [1:0]   secstat_r;
  logic [1:0]   secmask_r;
  logic [1:0]   secsev_r;
  logic         pvld_r;
  logic         pptr_r;
  logic         svld_r;
  logic         sptr_r;
  logic [31:0]  hdr_r [4];
  logic [31:0]  shdr_r [4];
  dbeh_pkg::dbeh_rd_t rd_st_r;
  logic         rd_pois_r;
  logic         perr_s;

  dbeh_sync2 u_sync
  (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (pci_parity_error_pin_in_n),
    .q       (perr_s)
  );

  // ****************************************************************
  // apb decode
  // ****************************************************************
  wire        setup_w = psel & ~penable;
  wire        wr_w    = psel & penable & pready & pwrite;
  wire [31:0] w1_w    = pwdata;
  wire wr_ctrl  = wr_w & (paddr == `DBEH_OFF_CTRL);
  wire wr_dev   = wr_w & (paddr == `DBEH_OFF_DEVSTAT);
  wire wr_ust   = wr_w & (paddr == `DBEH_OFF_UNCSTAT);
  wire wr_umk   = wr_w & (paddr == `DBEH_OFF_UNCMASK);
  wire wr_usv   = wr_w & (paddr == `DBEH_OFF_UNCSEV);
  wire wr_cst   = wr_w & (paddr == `DBEH_OFF_CORSTAT);
  wire wr_cmk   = wr_w & (paddr == `DBEH_OFF_CORMASK);
  wire wr_sst   = wr_w & (paddr == `DBEH_OFF_SECSTAT);
  wire wr_smk   = wr_w & (paddr == `DBEH_OFF_SECMASK);
  wire wr_ssv   = wr_w & (paddr == `DBEH_OFF_SECSEV);
  wire wr_imk   = wr_w & (paddr == `DBEH_OFF_IMASK);
  wire hdr_hit  = (paddr[7:4] == `DBEH_OFF_HDR >> 4);
  wire shdr_hit = (paddr[7:4] == `DBEH_OFF_SHDR >> 4);
  logic [31:0] ptr_rd;
  logic [31:0] rd_mux;
  logic        rd_ok;
  always_comb
  begin
    rd_ok  = 1'b1;
    rd_mux = 32'h0;
    case (paddr)
      `DBEH_OFF_CTRL:    rd_mux = {26'h0, ctrl_r};
      `DBEH_OFF_DEVSTAT: rd_mux = {25'h0, devstat_r};
      `DBEH_OFF_UNCSTAT: rd_mux = {30'h0, uncstat_r};
      `DBEH_OFF_UNCMASK: rd_mux = {30'h0, uncmask_r};
      `DBEH_OFF_UNCSEV:  rd_mux = {30'h0, uncsev_r};
      `DBEH_OFF_CORSTAT: rd_mux = {31'h0, corstat_r};
      `DBEH_OFF_CORMASK: rd_mux = {31'h0, cormask_r};
      `DBEH_OFF_SECSTAT: rd_mux = {30'h0, secstat_r};
      `DBEH_OFF_SECMASK: rd_mux = {30'h0, secmask_r};
      `DBEH_OFF_SECSEV:  rd_mux = {30'h0, secsev_r};
      `DBEH_OFF_PTR:     rd_mux = ptr_rd;
      `DBEH_OFF_IMASK:   rd_mux = {25'h0, imask_r};
      default:
      begin
        rd_ok  = hdr_hit | shdr_hit;
        rd_mux = hdr_hit ? hdr_r[paddr[3:2]] : (shdr_hit ? shdr_r[paddr[3:2]] : 32'h0);
      end
    endcase
  end

  // ****************************************************************
  // error classification
  // ****************************************************************
  wire see   = ctrl_r[`DBEH_C_SEE];
  wire sper  = ctrl_r[`DBEH_C_SPER];
  wire adv   = ev_poison & ~uncsev_r[`DBEH_U_POISONED_STATUS];
  wire adv_u = adv & ~cormask_r;
  wire perr_ev = ~perr_s & fwd_poison_wr;
  // valid only while the logged status bit is still set
  wire pvalid = pvld_r & uncstat_r[pptr_r];
  wire svalid = svld_r & secstat_r[sptr_r];
  // a pointer field reads as zero while it is not valid
  assign ptr_rd = {22'h0, svalid, svalid & sptr_r, 6'h0, pvalid, pvalid & pptr_r};

  logic [2:0] hit_v;
  logic [2:0] msk_v;
  logic [2:0] sev_v;
  logic [2:0] sf_v;
  logic [2:0] snf_v;
  logic [2:0] df_v;
  logic [2:0] dnf_v;
  logic [2:0] sse_v;
  assign hit_v = {ev_poison & ~adv, rd_err, ev_ecrc};
  assign msk_v = {uncmask_r[`DBEH_U_POISONED_STATUS], secmask_r[`DBEH_S_UDE], uncmask_r[`DBEH_U_ECRC]};
  assign sev_v = {1'b1, secsev_r[`DBEH_S_UDE], uncsev_r[`DBEH_U_ECRC]};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_src
      dbeh_err_if eif ();
      assign eif.hit       = hit_v[gi];
      assign eif.masked    = msk_v[gi];
      assign eif.sev_fatal = sev_v[gi];
      assign sf_v[gi]      = eif.send_ftl;
      assign snf_v[gi]     = eif.send_nf;
      assign df_v[gi]      = eif.det_ftl;
      assign dnf_v[gi]     = eif.det_nf;
      assign sse_v[gi]     = eif.sserr;
      dbeh_err_act u_act
      (
        .see  (see),
        .fen  (ctrl_r[`DBEH_C_FEN]),
        .nfen (ctrl_r[`DBEH_C_NFEN]),
        .e    (eif.act)
      );
    end
  endgenerate

  wire send_cor = adv_u & ctrl_r[`DBEH_C_CEN];
  wire send_ftl = |sf_v;
  wire send_nf  = |snf_v;
  wire [6:0] dev_set;
  assign dev_set[`DBEH_D_COR]  = adv;
  assign dev_set[`DBEH_D_NF]   = |dnf_v;
  assign dev_set[`DBEH_D_FTL]  = |df_v;
  assign dev_set[`DBEH_D_SSE]  = |sse_v;
  assign dev_set[`DBEH_D_DPE]  = ev_poison | ev_ecrc | rd_err;
  assign dev_set[`DBEH_D_MDP]  = ev_poison & ev_poison_cpl & ctrl_r[`DBEH_C_PPER];
  assign dev_set[`DBEH_D_SMDP] = sper & (rd_err | perr_ev);
  wire [1:0] unc_set = {ev_ecrc, (ev_poison & ~adv) | adv_u};
  wire [1:0] sec_set = {rd_err, perr_ev};
  wire log_ecrc = ev_ecrc & ~uncmask_r[`DBEH_U_ECRC];
  wire log_pois = unc_set[`DBEH_U_POISONED_STATUS] & ev_poison & ~uncmask_r[`DBEH_U_POISONED_STATUS];
  wire log_pri  = (log_ecrc | log_pois) & ~pvalid;
  wire log_ude  = rd_err & ~secmask_r[`DBEH_S_UDE];
  wire log_pad  = perr_ev & ~secmask_r[`DBEH_S_PAD];
  wire log_sec  = (log_ude | log_pad) & ~svalid;

  // ****************************************************************
  // status and control registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r    <= 6'h00;
      devstat_r <= 7'h00;
      imask_r   <= 7'h00;
      uncstat_r <= 2'h0;
      uncmask_r <= 2'h0;
      uncsev_r  <= 2'h0;
      corstat_r <= 1'b0;
      cormask_r <= 1'b0;
      secstat_r <= 2'h0;
      secmask_r <= 2'h0;
      secsev_r  <= 2'h0;
    end
    else
    begin
      if (wr_ctrl) ctrl_r <= w1_w[5:0];
      if (wr_imk) imask_r <= w1_w[6:0];
      if (wr_umk) uncmask_r <= w1_w[1:0];
      if (wr_usv) uncsev_r <= w1_w[1:0];
      if (wr_cmk) cormask_r <= w1_w[0];
      if (wr_smk) secmask_r <= w1_w[1:0];
      if (wr_ssv) secsev_r <= w1_w[1:0];
      // set wins over a write-one clear in the same cycle
      devstat_r <= (devstat_r & ~(w1_w[6:0] & {7{wr_dev}})) | dev_set;
      uncstat_r <= (uncstat_r & ~(w1_w[1:0] & {2{wr_ust}})) | unc_set;
      corstat_r <= (corstat_r & ~(w1_w[0] & wr_cst)) | adv;
      secstat_r <= (secstat_r & ~(w1_w[1:0] & {2{wr_sst}})) | sec_set;
    end
  end

  // ****************************************************************
  // header logs and first-error pointers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pvld_r <= 1'b0;
      pptr_r <= 1'b0;
      svld_r <= 1'b0;
      sptr_r <= 1'b0;
    end
    else
    begin
      if (log_pri)
      begin
        pvld_r <= 1'b1;
        pptr_r <= log_ecrc ? 1'b1 : 1'b0;
      end
      else if (!pvalid) pvld_r <= 1'b0;
      if (log_sec)
      begin
        svld_r <= 1'b1;
        sptr_r <= log_ude ? 1'b1 : 1'b0;
      end
      else if (!svalid) svld_r <= 1'b0;
    end
  end

  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_hdr
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          hdr_r[gi]  <= 32'h0;
          shdr_r[gi] <= 32'h0;
        end
        else
        begin
          if (log_pri) hdr_r[gi] <= ev_hdr[32*gi +: 32];
          if (log_sec) shdr_r[gi] <= ev_hdr[32*gi +: 32];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // immediate read tracking
  // ****************************************************************
  wire rd_done = (rd_st_r == dbeh_pkg::RD_FETCH) & rd_end;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rd_st_r   <= dbeh_pkg::RD_IDLE;
      rd_pois_r <= 1'b0;
    end
    else
    begin
      case (rd_st_r)
        dbeh_pkg::RD_IDLE:
        begin
          rd_pois_r <= 1'b0;
          if (rd_start) rd_st_r <= dbeh_pkg::RD_FETCH;
        end
        dbeh_pkg::RD_FETCH:
        begin
          // a data error does not stop the fetch
          if (rd_err) rd_pois_r <= 1'b1;
          if (rd_end) rd_st_r <= dbeh_pkg::RD_IDLE;
        end
        default: rd_st_r <= dbeh_pkg::RD_IDLE;
      endcase
    end
  end

  wire [2:0] term_st = (term_kind == dbeh_pkg::TRM_TA) ? `DBEH_CPL_CA : `DBEH_CPL_UR;

  // ****************************************************************
  // outputs
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata      <= 32'h0;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      pci_par_out <= 1'b0;
      fwd_drop    <= 1'b0;
      cpl_valid   <= 1'b0;
      cpl_status  <= `DBEH_CPL_SC;
      cpl_poison  <= 1'b0;
      msg_valid   <= 1'b0;
      msg_code    <= dbeh_pkg::MSG_COR;
      pci_parity_error_pin_out_n <= 1'b1;
      pci_parity_error_pin_oe_n  <= 1'b1;
      irq         <= 1'b0;
    end
    else
    begin
      pready <= 1'b1;
      if (setup_w)
      begin
        prdata  <= pwrite ? 32'h0 : rd_mux;
        pslverr <= ~rd_ok;
      end
      pci_par_out <= dp_par ^ dp_poison;
      fwd_drop    <= ev_ecrc;
      cpl_valid   <= rd_done | term_valid;
      cpl_status  <= rd_done ? `DBEH_CPL_SC : term_st;
      cpl_poison  <= rd_done & (rd_pois_r | rd_err);
      msg_valid   <= send_ftl | send_nf | send_cor;
      msg_code    <= send_ftl ? dbeh_pkg::MSG_FTL :
                     (send_nf ? dbeh_pkg::MSG_NF : dbeh_pkg::MSG_COR);
      pci_parity_error_pin_out_n <= 1'b0;
      pci_parity_error_pin_oe_n  <= ~(rd_err & sper);
      irq         <= |(devstat_r & imask_r);
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_ecrc_drop: assert property (@(posedge pclk) disable iff (!presetn)
    ev_ecrc |=> fwd_drop && devstat_r[`DBEH_D_DPE] && uncstat_r[`DBEH_U_ECRC])
    else $error("ecrc request not dropped");
  a_par_invert: assert property (@(posedge pclk) disable iff (!presetn)
    dp_poison |=> pci_par_out == !$past(dp_par))
    else $error("poisoned parity not inverted");
  a_rd_poison: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_done && (rd_pois_r || rd_err)) |=>
      cpl_valid && cpl_poison && cpl_status == `DBEH_CPL_SC)
    else $error("read error completion not poisoned");
  a_ta_status: assert property (@(posedge pclk) disable iff (!presetn)
    (term_valid && !rd_done) |=> cpl_valid &&
      (cpl_status == ($past(term_kind) == dbeh_pkg::TRM_TA ? `DBEH_CPL_CA : `DBEH_CPL_UR)))
    else $error("wrong termination status");
  a_adv_nomsg: assert property (@(posedge pclk) disable iff (!presetn)
    (adv && cormask_r && !ev_ecrc && !rd_err) |=> !msg_valid && corstat_r
      && devstat_r[`DBEH_D_COR])
    else $error("masked advisory sent a message");
  a_perr_drive: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_err && sper) |=> !pci_parity_error_pin_oe_n ##1
      (devstat_r[`DBEH_D_SMDP] || $past(wr_dev)))
    else $error("parity pin not driven");
  a_fatal_det: assert property (@(posedge pclk) disable iff (!presetn)
    (ev_poison && uncsev_r[`DBEH_U_POISONED_STATUS]) |=> devstat_r[`DBEH_D_FTL]
      && uncstat_r[`DBEH_U_POISONED_STATUS] && devstat_r[`DBEH_D_DPE])
    else $error("fatal detected bit not set");
  a_ptr_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (pvalid && !wr_ust) |=> $stable(hdr_r[0]) && $stable(pptr_r))
    else $error("header log overwritten");
endmodule

/* File: dbeh_map.svh */
// register offsets, field positions and codes of the downstream error handler
`ifndef DBEH_MAP_SVH
`define DBEH_MAP_SVH
`define DBEH_OFF_CTRL     8'h00
`define DBEH_OFF_DEVSTAT  8'h04
`define DBEH_OFF_UNCSTAT  8'h08
`define DBEH_OFF_UNCMASK  8'h0C
`define DBEH_OFF_UNCSEV   8'h10
`define DBEH_OFF_CORSTAT  8'h14
`define DBEH_OFF_CORMASK  8'h18
`define DBEH_OFF_SECSTAT  8'h1C
`define DBEH_OFF_SECMASK  8'h20
`define DBEH_OFF_SECSEV   8'h24
`define DBEH_OFF_PTR      8'h28
`define DBEH_OFF_IMASK    8'h2C
`define DBEH_OFF_HDR      8'h30
`define DBEH_OFF_SHDR     8'h40
// control bits
`define DBEH_C_SEE   0
`define DBEH_C_FEN   1
`define DBEH_C_NFEN  2
`define DBEH_C_CEN   3
`define DBEH_C_PPER  4
`define DBEH_C_SPER  5
// device status bits
`define DBEH_D_COR   0
`define DBEH_D_NF    1
`define DBEH_D_FTL   2
`define DBEH_D_SSE   3
`define DBEH_D_DPE   4
`define DBEH_D_MDP   5
`define DBEH_D_SMDP  6
// uncorrectable, correctable and secondary fields
`define DBEH_U_POISONED_STATUS  0
`define DBEH_U_ECRC  1
`define DBEH_K_ANF   0
`define DBEH_S_PAD   0
`define DBEH_S_UDE   1
`define DBEH_P_SEC   8
// completion status codes
`define DBEH_CPL_SC  3'h0
`define DBEH_CPL_UR  3'h1
`define DBEH_CPL_CA  3'h4
`endif

/* File: dbeh_pkg.sv */
// types of the downstream error handler
package dbeh_pkg;
  typedef enum logic [1:0] {MSG_COR = 2'b00, MSG_NF = 2'b01, MSG_FTL = 2'b11} dbeh_msg_t;
  typedef enum logic [1:0] {TRM_WRDE = 2'b00, TRM_MA = 2'b01, TRM_TA = 2'b10} dbeh_term_t;
  typedef enum logic {RD_IDLE = 1'b0, RD_FETCH = 1'b1} dbeh_rd_t;
endpackage

/* File: dbeh_err_if.sv */
// one uncorrectable error source and its reporting verdict
`timescale 1ns/1ps
interface dbeh_err_if;
  logic hit;
  logic masked;
  logic sev_fatal;
  logic send_ftl;
  logic send_nf;
  logic det_ftl;
  logic det_nf;
  logic sserr;
  modport src (output hit, output masked, output sev_fatal,
               input send_ftl, input send_nf, input det_ftl, input det_nf, input sserr);
  modport act (input hit, input masked, input sev_fatal,
               output send_ftl, output send_nf, output det_ftl, output det_nf, output sserr);
endinterface

/* File: dbeh_sync2.sv */
// two-flop synchroniser for a pin level
`timescale 1ns/1ps
module dbeh_sync2
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // level
  input  wire logic d,
  output logic      q
);
  logic meta_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_r <= 1'b1;
      q      <= 1'b1;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

/* File: dbeh_err_act.sv */
// message and detected-bit verdict for one uncorrectable error
`timescale 1ns/1ps
module dbeh_err_act
(
  // enables
  input  wire logic see,
  input  wire logic fen,
  input  wire logic nfen,
  // error source
  dbeh_err_if.act   e
);
  wire send_w = e.hit & ~e.masked;
  assign e.send_ftl = send_w & e.sev_fatal & (see | fen);
  assign e.send_nf  = send_w & ~e.sev_fatal & (see | nfen);
  assign e.det_ftl  = e.hit & e.sev_fatal;
  assign e.det_nf   = e.hit & ~e.sev_fatal;
  assign e.sserr    = see & (e.send_ftl | e.send_nf);
endmodule

/* File: dbeh_pci_tgt.sv */
// pci target model: checks forwarded parity and drives the parity error wire
`timescale 1ns/1ps
module dbeh_pci_tgt
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // data phase seen on the bus
  input  wire logic check_en,
  input  wire logic wr_phase,
  input  wire logic good_par,
  input  wire logic bus_par,
  // parity error wire
  input  wire logic drv_out_n,
  input  wire logic drv_oe_n,
  output logic      perr_wire_n
);
  logic perr_r;
  // target flags a write data phase whose parity is wrong
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      perr_r <= 1'b0;
    else
      perr_r <= check_en & wr_phase & (bus_par != good_par);
  end
  // pulled-up wire, low while either party pulls it
  assign perr_wire_n = ~(perr_r | (~drv_oe_n & ~drv_out_n));
endmodule

/* File: downstream_bridge_error_handler_tb_top.sv */
// self-checking bench of the downstream error handler
`timescale 1ns/1ps
`include "dbeh_map.svh"
module downstream_bridge_error_handler_tb_top;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, rd, c;
  logic         ev_poison, ev_poison_cpl, ev_ecrc, dp_par, dp_poison;
  logic [127:0] ev_hdr, hv;
  logic         fwd_poison_wr, pci_par_out, fwd_drop, rd_start, rd_err, rd_end;
  logic         term_valid, cpl_valid, cpl_poison, msg_valid, irq, tgt_en;
  logic [1:0]   term_kind, msg_code, last_code;
  logic [2:0]   cpl_status, last_status;
  logic         last_poison, err, s, snd;
  logic         pci_parity_error_pin_in_n, pci_parity_error_pin_out_n;
  logic         pci_parity_error_pin_oe_n;
  int           n_mismatch, comparisons, n_msg, n_cpl, n_drop, n_oe, m, p, d, o;

  dbeh_top i_dbeh_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .ev_poison, .ev_poison_cpl, .ev_ecrc, .ev_hdr,
    .dp_par, .dp_poison, .fwd_poison_wr, .pci_par_out, .fwd_drop, .rd_start,
    .rd_err, .rd_end, .term_valid, .term_kind, .cpl_valid, .cpl_status, .cpl_poison,
    .msg_valid, .msg_code, .pci_parity_error_pin_in_n, .pci_parity_error_pin_out_n,
    .pci_parity_error_pin_oe_n, .irq);
  dbeh_pci_tgt i_dbeh_pci_tgt (.pclk, .presetn, .check_en(tgt_en),
    .wr_phase(fwd_poison_wr), .good_par(dp_par), .bus_par(pci_par_out),
    .drv_out_n(pci_parity_error_pin_out_n), .drv_oe_n(pci_parity_error_pin_oe_n),
    .perr_wire_n(pci_parity_error_pin_in_n));

  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // one-cycle outputs counted as they pass
  always @(posedge pclk)
  begin
    n_msg += (msg_valid === 1'b1);
    n_cpl += (cpl_valid === 1'b1);
    n_drop += (fwd_drop === 1'b1);
    n_oe += (pci_parity_error_pin_oe_n === 1'b0);
    if (msg_valid === 1'b1) last_code = msg_code;
    if (cpl_valid === 1'b1) {last_status, last_poison} = {cpl_status, cpl_poison};
  end

  task stop_test;
    $display("counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, dat};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (n >= 16)
    begin
      n_mismatch++;
      stop_test;
    end
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask

  task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  task setup(input logic [31:0] ctl, um, us, cm);
    apb(1'b1, `DBEH_OFF_DEVSTAT, 32'hFFFFFFFF);
    apb(1'b1, `DBEH_OFF_UNCSTAT, 32'hFFFFFFFF);
    apb(1'b1, `DBEH_OFF_CORSTAT, 32'hFFFFFFFF);
    apb(1'b1, `DBEH_OFF_SECSTAT, 32'hFFFFFFFF);
    apb(1'b1, `DBEH_OFF_CTRL, ctl);
    apb(1'b1, `DBEH_OFF_UNCMASK, um);
    apb(1'b1, `DBEH_OFF_UNCSEV, us);
    apb(1'b1, `DBEH_OFF_CORMASK, cm);
    apb(1'b1, `DBEH_OFF_SECMASK, um);
    apb(1'b1, `DBEH_OFF_SECSEV, us);
  endtask

  // pulses one cycle of events, then waits for every answer to land
  task fire(input logic [5:0] v, input logic [127:0] h);
    @(posedge pclk);
    ev_hdr <= h;
    {term_valid, rd_end, rd_err, rd_start, ev_ecrc, ev_poison} <= v;
    @(posedge pclk);
    {term_valid, rd_end, rd_err, rd_start, ev_ecrc, ev_poison} <= 6'h00;
    repeat (3) @(posedge pclk);
  endtask

  function logic pz_snd(logic sv, cm, um, logic [5:0] k);
    return sv ? (~um & (k[0] | k[1])) : (~cm & k[3]);
  endfunction

  function logic [31:0] pz_dev(logic sv, um, cpl, logic [5:0] k);
    return {25'h0, 1'b0, cpl & k[4], 1'b1, sv & ~um & k[0], sv, 1'b0, ~sv};
  endfunction

  initial
  begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    stop_test;
  end

  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, tgt_en} = '0;
    {ev_poison, ev_poison_cpl, ev_ecrc, ev_hdr, dp_par, dp_poison} = '0;
    {fwd_poison_wr, rd_start, rd_err, rd_end, term_valid, term_kind} = '0;
    c = $urandom(32'hBC0149CA);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 80; a += 4) rchk("reset value", a[7:0], 32'h0);
    apb(1'b0, 8'hF0, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    $display("test registers done");
    for (int i = 0; i < 16; i++)
    begin
      c = $urandom;
      @(posedge pclk);
      {dp_par, dp_poison} <= c[1:0];
      @(posedge pclk);
      @(negedge pclk);
      chk("parity out", {31'h0, c[0] ^ c[1]}, {31'h0, pci_par_out});
    end
    $display("test parity done");
    for (int i = 0; i < 8; i++)
    begin
      c = $urandom;
      s = i[2];
      setup({26'h0, c[5:0]}, {31'h0, i[0]}, {31'h0, s}, {31'h0, i[1]});
      ev_poison_cpl <= c[6];
      m = n_msg;
      hv = {$urandom, $urandom, $urandom, $urandom};
      fire(6'h01, hv);
      snd = pz_snd(s, i[1], i[0], c[5:0]);
      chk("poison msgs", 32'(snd), 32'(n_msg - m));
      if (snd) chk("poison code", {30'h0, s, s}, {30'h0, last_code});
      rchk("devstat", `DBEH_OFF_DEVSTAT, pz_dev(s, i[0], c[6], c[5:0]));
      rchk("uncstat", `DBEH_OFF_UNCSTAT, {31'h0, s | ~i[1]});
      rchk("corstat", `DBEH_OFF_CORSTAT, {31'h0, ~s});
      snd = ~i[0] & (s | ~i[1]);
      rchk("pointer", `DBEH_OFF_PTR, {30'h0, snd, 1'b0});
      if (snd) rchk("header", `DBEH_OFF_HDR, hv[31:0]);
    end
    $display("test poison done");
    for (int i = 0; i < 4; i++)
    begin
      c = $urandom;
      s = i[1];
      setup({26'h0, c[5:0]}, {30'h0, i[0], 1'b0}, {30'h0, s, 1'b0}, 32'h0);
      {m, d} = {n_msg, n_drop};
      hv = {$urandom, $urandom, $urandom, $urandom};
      fire(6'h02, hv);
      fire(6'h02, ~hv);
      snd = ~i[0] & (c[0] | (s ? c[1] : c[2]));
      chk("drops", 32'h2, 32'(n_drop - d));
      chk("ecrc msgs", 32'(2 * snd), 32'(n_msg - m));
      if (snd) chk("ecrc code", {30'h0, s, 1'b1}, {30'h0, last_code});
      rchk("devstat", `DBEH_OFF_DEVSTAT, {27'h0, 1'b1, snd & c[0], s, ~s, 1'b0});
      rchk("uncstat", `DBEH_OFF_UNCSTAT, 32'h2);
      rchk("pointer", `DBEH_OFF_PTR, i[0] ? 32'h0 : 32'h3);
      if (!i[0]) rchk("first header", `DBEH_OFF_HDR, hv[31:0]);
    end
    $display("test ecrc done");
    for (int i = 0; i < 2; i++)
    begin
      c = $urandom;
      s = c[7];
      setup({26'h0, i[0], c[4:0]}, 32'h0, {30'h0, s, 1'b0}, 32'h0);
      {m, p, o} = {n_msg, n_cpl, n_oe};
      hv = {$urandom, $urandom, $urandom, $urandom};
      fire(6'h04, 128'h0);
      fire(6'h08, hv);
      chk("early completion", 32'h0, 32'(n_cpl - p));
      chk("parity pin drives", 32'(i[0]), 32'(n_oe - o));
      fire(6'h10, 128'h0);
      chk("completions", 32'h1, 32'(n_cpl - p));
      chk("completion", {28'h0, `DBEH_CPL_SC, 1'b1}, {28'h0, last_status, last_poison});
      snd = c[0] | (s ? c[1] : c[2]);
      chk("read msgs", 32'(snd), 32'(n_msg - m));
      if (snd) chk("read code", {30'h0, s, 1'b1}, {30'h0, last_code});
      rchk("devstat", `DBEH_OFF_DEVSTAT, {25'h0, i[0], 2'b01, snd & c[0], s, ~s, 1'b0});
      rchk("secstat", `DBEH_OFF_SECSTAT, 32'h2);
      rchk("pointer", `DBEH_OFF_PTR, 32'h300);
      rchk("sec header", `DBEH_OFF_SHDR, hv[31:0]);
    end
    $display("test read done");
    for (int k = 0; k < 3; k++)
    begin
      term_kind <= k[1:0];
      p = n_cpl;
      fire(6'h20, 128'h0);
      chk("term completions", 32'h1, 32'(n_cpl - p));
      chk("term status", {28'h0, k == 2 ? `DBEH_CPL_CA : `DBEH_CPL_UR, 1'b0},
          {28'h0, last_status, last_poison});
    end
    $display("test terminations done");
    c = $urandom;
    setup({26'h0, c[5:0]}, 32'h0, 32'h0, 32'h0);
    m = n_msg;
    @(posedge pclk);
    {dp_par, dp_poison, fwd_poison_wr, tgt_en} <= {c[6], 3'b111};
    repeat (8) @(posedge pclk);
    {dp_poison, fwd_poison_wr, tgt_en} <= 3'b000;
    repeat (4) @(posedge pclk);
    chk("pin msgs", 32'h0, 32'(n_msg - m));
    rchk("secstat", `DBEH_OFF_SECSTAT, 32'h1);
    rchk("devstat", `DBEH_OFF_DEVSTAT, {25'h0, c[5], 6'h0});
    rchk("pointer", `DBEH_OFF_PTR, 32'h200);
    $display("test parity pin done");
    setup(32'h0, 32'h0, 32'h0, 32'h0);
    apb(1'b1, `DBEH_OFF_IMASK, 32'h10);
    fire(6'h01, 128'h0);
    chk("irq raised", 32'h1, {31'h0, irq});
    apb(1'b1, `DBEH_OFF_DEVSTAT, 32'hFFFFFFFF);
    repeat (3) @(posedge pclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    apb(1'b1, `DBEH_OFF_IMASK, 32'h0);
    fire(6'h01, 128'h0);
    chk("irq masked", 32'h0, {31'h0, irq});
    $display("test interrupt done");
    stop_test;
  end
endmodule
